// >>> logic/lsgp_port_regs.vh
`ifndef LSGP_PORT_REGS_VH
`define LSGP_PORT_REGS_VH
`define LSGP_ADDR_W          4
`define LSGP_OFF_DATA        4'h0
`define LSGP_OFF_DIR         4'h1
`define LSGP_OFF_PULLUP      4'h2
`define LSGP_RST_DATA        8'h00
`define LSGP_RST_DIR         8'h00
`define LSGP_RST_PULLUP      8'h00
`define LSGP_DIR_READ        8'hFF
`define LSGP_UNMAPPED_READ   8'h00
`define LSGP_HI_SEG_LO       4'h4
`define LSGP_HI_SEG_HI       4'hB
`define LSGP_LO_SEG_LO       4'h3
`define LSGP_LO_SEG_HI       4'hA
`define LSGP_SEG_BASE        9
`endif

// >>> logic/lsgp_port.v
`timescale 1ns/1ps
`include "lsgp_port_regs.vh"

// Functional notes
// - Output bits read back the latch
// - Input bits read the sampled pin
// - Eight-bit data latch, resets to zero
// - Direction one drives, zero inputs
// - Direction register write-only, reads ones
// - Settings apply only in general I/O
// - Pull-up bit enables input pull-up
// - Output pins keep pull-up off
// - All pull-ups off after reset
// - Eight-bit pull-up register, resets zero
// - Upper nibble segments for codes 4..B
// - Lower nibble segments for codes 3..A
// - Segment-select code is a block input
module lsgp_port #(
	parameter WIDTH = 8
) (
	input  wire                    ref_clk,
	input  wire                    sys_rst,
	input  wire [`LSGP_ADDR_W-1:0] busAddr,
	input  wire [WIDTH-1:0]        busWrData,
	input  wire                    busWrStb,
	input  wire                    busRdStb,
	output reg  [WIDTH-1:0]        busRdData,
	input  wire [3:0]              segmentSelectCode,
	input  wire [WIDTH-1:0]        segmentOutput,
	input  wire [WIDTH-1:0]        pinIn,
	output reg  [WIDTH-1:0]        pinOut,
	output reg  [WIDTH-1:0]        pinOutEn_n,
	output reg  [WIDTH-1:0]        pullupOn,
	output reg  [WIDTH-1:0]        segmentMode
);

	localparam HALF       = WIDTH / 2;
	localparam MODE_IN    = 3'b001;
	localparam MODE_OUT   = 3'b010;
	localparam MODE_SEG   = 3'b100;
	localparam SEL_NONE   = 3'b000;
	localparam SEL_DATA   = 3'b001;
	localparam SEL_DIR    = 3'b010;
	localparam SEL_PULLUP = 3'b100;

	// Software-visible registers
	reg  [WIDTH-1:0] portDataLatch_reg;
	reg  [WIDTH-1:0] pinDirectionSelect_reg;
	reg  [WIDTH-1:0] inputPullupEnable_reg;

	// Pin synchroniser stages
	reg  [WIDTH-1:0] sync1_reg;
	reg  [WIDTH-1:0] sync2_reg;
	reg  [WIDTH-1:0] sync3_reg;
	reg  [WIDTH-1:0] pinLevel_reg;

	// Decode and next values
	reg  [WIDTH-1:0] rdData_next;
	wire [WIDTH-1:0] stagesAgree;
	wire [WIDTH-1:0] segMode_next;
	wire [WIDTH-1:0] pinOut_next;
	wire [WIDTH-1:0] pinOutEn_n_next;
	wire [WIDTH-1:0] pullupOn_next;
	wire [WIDTH-1:0] dataRead_w;
	wire [2:0]       regSel;
	wire             hiSeg;
	wire             loSeg;
	wire             wrData;
	wire             wrDir;
	wire             wrPullup;
	genvar           g;

	function inRange;
		input [3:0] code;
		input [3:0] lo;
		input [3:0] hi;
		begin
			inRange = (code >= lo) && (code <= hi);
		end
	endfunction

	// Register select, one-hot
	function [2:0] regSelect;
		input [`LSGP_ADDR_W-1:0] addr;
		begin
			case (addr)
				`LSGP_OFF_DATA: begin
					regSelect = SEL_DATA;
				end
				`LSGP_OFF_DIR: begin
					regSelect = SEL_DIR;
				end
				`LSGP_OFF_PULLUP: begin
					regSelect = SEL_PULLUP;
				end
				default: begin
					regSelect = SEL_NONE;
				end
			endcase
		end
	endfunction

	// Pin role from segment flag and direction bit
	function [2:0] pinModeOf;
		input segBit;
		input dirBit;
		begin
			if (segBit) begin
				pinModeOf = MODE_SEG;
			end else if (dirBit) begin
				pinModeOf = MODE_OUT;
			end else begin
				pinModeOf = MODE_IN;
			end
		end
	endfunction

	// Level presented to the pad
	function padLevel;
		input [2:0] mode;
		input       latchBit;
		input       segBit;
		begin
			case (mode)
				MODE_SEG: begin
					padLevel = segBit;
				end
				MODE_OUT: begin
					padLevel = latchBit;
				end
				MODE_IN: begin
					padLevel = latchBit;
				end
				default: begin
					padLevel = 1'b0;
				end
			endcase
		end
	endfunction

	// Pad enable, low drives
	function padEnable_n;
		input [2:0] mode;
		begin
			case (mode)
				MODE_SEG: begin
					padEnable_n = 1'b0;
				end
				MODE_OUT: begin
					padEnable_n = 1'b0;
				end
				MODE_IN: begin
					padEnable_n = 1'b1;
				end
				default: begin
					padEnable_n = 1'b1;
				end
			endcase
		end
	endfunction

	// Pull-up only on general inputs
	function pullupLevel;
		input [2:0] mode;
		input       pullBit;
		begin
			case (mode)
				MODE_SEG: begin
					pullupLevel = 1'b0;
				end
				MODE_OUT: begin
					pullupLevel = 1'b0;
				end
				MODE_IN: begin
					pullupLevel = pullBit;
				end
				default: begin
					pullupLevel = 1'b0;
				end
			endcase
		end
	endfunction

	// Segment decode
	assign hiSeg = inRange(segmentSelectCode, `LSGP_HI_SEG_LO, `LSGP_HI_SEG_HI);
	assign loSeg = inRange(segmentSelectCode, `LSGP_LO_SEG_LO, `LSGP_LO_SEG_HI);

	// Register address decode
	assign regSel   = regSelect(busAddr);
	assign wrData   = busWrStb & (regSel == SEL_DATA);
	assign wrDir    = busWrStb & (regSel == SEL_DIR);
	assign wrPullup = busWrStb & (regSel == SEL_PULLUP);

	// Data latch
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			portDataLatch_reg <= `LSGP_RST_DATA;
		end else if (wrData) begin
			portDataLatch_reg <= busWrData;
		end
	end

	// Direction register
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pinDirectionSelect_reg <= `LSGP_RST_DIR;
		end else if (wrDir) begin
			pinDirectionSelect_reg <= busWrData;
		end
	end

	// Pull-up enable register
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			inputPullupEnable_reg <= `LSGP_RST_PULLUP;
		end else if (wrPullup) begin
			inputPullupEnable_reg <= busWrData;
		end
	end

	// First synchroniser stage
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			sync1_reg <= {WIDTH{1'b0}};
		end else begin
			sync1_reg <= pinIn;
		end
	end

	// Second stage
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			sync2_reg <= {WIDTH{1'b0}};
		end else begin
			sync2_reg <= sync1_reg;
		end
	end

	// Third stage
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			sync3_reg <= {WIDTH{1'b0}};
		end else begin
			sync3_reg <= sync2_reg;
		end
	end

	// Accept a level once stages two and three agree
	assign stagesAgree = ~(sync2_reg ^ sync3_reg);
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pinLevel_reg <= {WIDTH{1'b0}};
		end else begin
			pinLevel_reg <= (stagesAgree & sync3_reg) | (~stagesAgree & pinLevel_reg);
		end
	end

	// Per-pin decode
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : gen_pin
			wire [2:0] pinMode;

			if (g >= HALF) begin : gen_hi
				assign segMode_next[g] = hiSeg;
			end else begin : gen_lo
				assign segMode_next[g] = loSeg;
			end

			assign pinMode            = pinModeOf(segMode_next[g], pinDirectionSelect_reg[g]);
			assign pinOut_next[g]     = padLevel(pinMode, portDataLatch_reg[g], segmentOutput[g]);
			assign pinOutEn_n_next[g] = padEnable_n(pinMode);
			assign pullupOn_next[g]   = pullupLevel(pinMode, inputPullupEnable_reg[g]);
			assign dataRead_w[g]      = pinDirectionSelect_reg[g] ? portDataLatch_reg[g] : pinLevel_reg[g];
		end
	endgenerate

	// Read mux
	always @* begin
		rdData_next = `LSGP_UNMAPPED_READ;
		case (regSel)
			SEL_DATA: begin
				rdData_next = dataRead_w;
			end
			SEL_DIR: begin
				rdData_next = `LSGP_DIR_READ;
			end
			SEL_PULLUP: begin
				rdData_next = inputPullupEnable_reg;
			end
			default: begin
				rdData_next = `LSGP_UNMAPPED_READ;
			end
		endcase
	end

	// Read data stands one cycle
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			busRdData <= {WIDTH{1'b0}};
		end else if (busRdStb) begin
			busRdData <= rdData_next;
		end else begin
			busRdData <= {WIDTH{1'b0}};
		end
	end

	// Segment mode flags
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			segmentMode <= {WIDTH{1'b0}};
		end else begin
			segmentMode <= segMode_next;
		end
	end

	// Pad level
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pinOut <= {WIDTH{1'b0}};
		end else begin
			pinOut <= pinOut_next;
		end
	end

	// Pad enable
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pinOutEn_n <= {WIDTH{1'b1}};
		end else begin
			pinOutEn_n <= pinOutEn_n_next;
		end
	end

	// Pull-up control
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pullupOn <= {WIDTH{1'b0}};
		end else begin
			pullupOn <= pullupOn_next;
		end
	end

endmodule // lsgp_port

// >>> bench/lsgp_port_asserts.sv
`timescale 1ns/1ps
module lsgp_port_asserts (
	input wire		ref_clk,
	input wire		sys_rst,
	input wire [3:0]	busAddr,
	input wire		busWrStb,
	input wire		busRdStb,
	input wire [7:0]	busRdData,
	input wire [3:0]	segmentSelectCode,
	input wire [7:0]	pinIn,
	input wire [7:0]	pinOut,
	input wire [7:0]	pinOutEn_n,
	input wire [7:0]	pullupOn,
	input wire [7:0]	segmentMode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence rq; !$past(busWrStb) && busRdStb && busAddr == 4'h0 && segmentMode == 8'h00; endsequence
	AST_DIR_RD: assert property (busRdStb && busAddr == 4'h1 |=> busRdData == 8'hFF) else $error("dir read");
	AST_RD_OUT: assert property (rq ##0 pinOutEn_n == 8'h00 |=> busRdData == $past(pinOut))
		else $error("out read");
	AST_RD_IN: assert property ($stable(pinIn) [*6] ##0 rq ##0 pinOutEn_n == 8'hFF |=> busRdData == $past(pinIn))
		else $error("in read");
	AST_PU_OUT: assert property ((pullupOn & ~pinOutEn_n) == 8'h00) else $error("pullup on output");
	AST_SEG_HI: assert property (!$past(sys_rst) |-> segmentMode[7:4] == {4{$past(segmentSelectCode) inside {[4'h4:4'hB]}}})
		else $error("high seg");
	AST_SEG_LO: assert property (!$past(sys_rst) |-> segmentMode[3:0] == {4{$past(segmentSelectCode) inside {[4'h3:4'hA]}}})
		else $error("low seg");
	AST_SEG_EN: assert property ((segmentMode & $past(segmentMode) & pinOutEn_n) == 8'h00) else $error("seg drive");
	AST_RST: assert property (disable iff (1'b0) sys_rst |=> pullupOn == 8'h00 && pinOutEn_n == 8'hFF)
		else $error("reset state");
endmodule // lsgp_port_asserts
bind lsgp_port lsgp_port_asserts lsgp_port_asserts_inst (.ref_clk, .sys_rst, .busAddr, .busWrStb, .busRdStb,
	.busRdData, .segmentSelectCode, .pinIn, .pinOut, .pinOutEn_n, .pullupOn, .segmentMode);

// >>> bench/lsgp_pin_model.sv
`timescale 1ns/1ps
module lsgp_pin_model (
	input wire [7:0]	extDrive,
	output wire [7:0]	pinIn
);
	// Strong outside source wins over port driver
	assign pinIn = extDrive;
endmodule // lsgp_pin_model

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
	logic		ref_clk = 0, sys_rst = 1, busWrStb = 0, busRdStb = 0;
	logic [3:0]	busAddr = 4'h0, segmentSelectCode = 4'h0;
	logic [7:0]	busWrData = 8'h00, segmentOutput = 8'h5A, extDrive = 8'hC3;
	wire [7:0]	busRdData, pinIn, pinOut, pinOutEn_n, pullupOn, segmentMode;
	int		n_fail = 0, checks = 0;
	always #2.5 ref_clk = ~ref_clk;
	lsgp_port lsgp_port_inst (.ref_clk, .sys_rst, .busAddr, .busWrData, .busWrStb, .busRdStb, .busRdData,
		.segmentSelectCode, .segmentOutput, .pinIn, .pinOut, .pinOutEn_n, .pullupOn, .segmentMode);
	lsgp_pin_model lsgp_pin_model_inst (.extDrive, .pinIn);
	task tally_and_finish;
		if (n_fail == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] want);
		checks++;
		if (got !== want) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		busAddr <= a;
		busWrData <= d;
		busWrStb <= 1;
		@(posedge ref_clk);
		busWrStb <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] want);
		@(posedge ref_clk);
		busAddr <= a;
		busRdStb <= 1;
		@(posedge ref_clk);
		busRdStb <= 0;
		@(negedge ref_clk);
		chk(busRdData, want);
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		sys_rst <= 0;
		idle(6);
		rd(0, 8'hC3);
		rd(1, 8'hFF);
		rd(2, 8'h00);
		chk(pullupOn, 8'h00);
		wr(1, 8'hFF);
		rd(0, 8'h00);
		wr(0, 8'hA5);
		wr(2, 8'hFF);
		wr(3, 8'h00);
		rd(2, 8'hFF);
		rd(0, 8'hA5);
		rd(3, 8'h00);
		chk(pinOut | pinOutEn_n | pullupOn, 8'hA5);
		wr(1, 8'h0F);
		idle(1);
		chk(pullupOn, 8'hF0);
		rd(0, 8'hC5);
		for (int c = 0; c < 16; c++) begin
			@(posedge ref_clk);
			segmentSelectCode <= c[3:0];
			idle(3);
			chk(segmentMode, {{4{c > 3 && c < 12}}, {4{c > 2 && c < 11}}});
			chk((pullupOn | pinOut ^ segmentOutput) & segmentMode, 8'h00);
		end
		tally_and_finish;
	end
	initial begin
		#3000;
		n_fail++;
		tally_and_finish;
	end
endmodule // tb
